// [rtl/adcc_pkg.sv]
// Purpose: Shared constants for the converter control block.
// Assumes: 10 MHz system clock, AXI4-Lite register access.
// Notes: Contract
// Contract
// - Conversions only start while the converter enable bit is one.
// - A write clearing enable is ignored while busy or complete flag set.
// - Second DAC enable output follows its control bit directly.
// - First DAC enable is writable only while busy and flag are zero.
// - CPU-clocked conversion takes exactly 31 machine cycles.
// - Sequencing works with CPU clock up to 20 MHz.
// - Clock select bit switches conversion timing to the RC oscillator.
// - RC oscillator runs for the converter regardless of CPU clock.
// - RC-clocked conversions keep running through power-down.
// - RC mode: 3 to 4 machine cycles sync plus 108 RC clocks.
// - Writing start begins a conversion; bit reads busy until flag sets.
// - No new conversion starts while the complete flag is set.
// - Result lands in first DAC register and holds until next start; the code also takes a result write while busy and flag are zero.
// - Channel select bits cannot change during a conversion.
package adcc_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'hc0;
  localparam logic [7:0] RESULT_OFF = 8'hc4;
  localparam logic [7:0] DAC2_OFF = 8'hc8;

  // Control register fields; BIT_SETTLED is bit 8 of the result register read
  localparam int BIT_ENABLE = 7;
  localparam int BIT_DAC2_EN = 6;
  localparam int BIT_SECOND_DAC_REG_EN = 5;
  localparam int BIT_FLAG = 4;
  localparam int BIT_START = 3;
  localparam int BIT_RC_SEL = 2;
  localparam int BIT_CHAN_HI = 1;
  localparam int BIT_CHAN_LO = 0;
  localparam int BIT_SETTLED = 8;

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DAC_RESET = 8'h00;

  // Timing
  localparam int CLK_MHZ = 10;
  localparam int MAX_CPU_MHZ = 20;
  localparam int SETTLE_US = 10;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int MC_CLOCKS = 6;
  localparam int CPU_CONV_MC = 31;
  localparam int CPU_CONV_CYC = CPU_CONV_MC * MC_CLOCKS;
  localparam int CPU_SETTLE = 2;
  localparam int CPU_TRIAL = (CPU_CONV_CYC - CPU_SETTLE) / 8;
  localparam int RC_SYNC_MC = 3;
  localparam int RC_SYNC_CYC = RC_SYNC_MC * MC_CLOCKS;
  localparam int RC_CONV_TICKS = 108;
  localparam int RC_SETTLE = 4;
  localparam int RC_TRIAL = (RC_CONV_TICKS - RC_SETTLE) / 8;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Sequencer states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SYNC = 5'h02,
    ST_SETTLE = 5'h04,
    ST_TRIAL = 5'h08,
    ST_ALIGN = 5'h10
  } adcc_state_t;

endpackage

// [rtl/adcc_conv_ctrl.sv]
// Purpose: Control register and SAR sequencer of the 4-input A/D converter.
// Assumes: Comparator, ladder and RC oscillator are outside; pins async.
// Notes: RC mode counts synchronised RC oscillator edges on the bus clock.
`timescale 1ns/1ps
module adcc_conv_ctrl
  import adcc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Asynchronous inputs from the analog side and power control
  input wire logic power_down,
  input wire logic rc_osc_clk,
  input wire logic comp_high,
  // Analog control outputs and completion interrupt
  output logic converter_enable,
  output logic rc_osc_enable,
  output logic first_dac_enable,
  output logic second_dac_enable,
  output logic [3:0] analog_sel,
  output logic [7:0] first_dac_code,
  output logic [7:0] second_dac_code,
  output logic conv_irq
);

  // One-hot input select from channel code
  function automatic logic [3:0] chan_onehot(input logic [1:0] ch);
    chan_onehot = 4'h1 << ch;
  endfunction

  // Word-aligned register hit
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [7:0] off);
    reg_hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
  endfunction

  // Reset release and input synchronisers
  logic rst_meta_n;
  logic rst_s_n;
  logic [2:0] in_meta;
  logic [2:0] in_sync;
  logic rc_prev;
  logic pd_s;
  logic rc_edge;
  logic comp_s;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_s_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_s_n <= rst_meta_n;
    end
  end

  // Two stages before use; edge detect reads only the second stage on
  always_ff @(posedge clock or negedge rst_s_n) begin
    if (!rst_s_n) begin
      in_meta <= 3'h0;
      in_sync <= 3'h0;
      rc_prev <= 1'b0;
    end else begin
      in_meta <= {comp_high, rc_osc_clk, power_down};
      in_sync <= in_meta;
      rc_prev <= in_sync[1];
    end
  end

  assign pd_s = in_sync[0];
  assign rc_edge = in_sync[1] & ~rc_prev;
  assign comp_s = in_sync[2];

  // Register and sequencer state
  logic enable, next_enable;
  logic dac2_en, next_dac2_en;
  logic second_dac_reg_en, next_second_dac_reg_en;
  logic flag, next_flag;
  logic busy, next_busy;
  logic rc_sel, next_rc_sel;
  logic [1:0] chan, next_chan;
  logic [7:0] first_dac_result_reg, next_first_dac_result_reg;
  logic [7:0] dac2, next_dac2;
  logic conv_rc, next_conv_rc;
  adcc_state_t state, next_state;
  logic [7:0] cnt, next_cnt;
  logic [2:0] bitn, next_bitn;
  logic [2:0] mc_div, next_mc_div;
  logic [7:0] en_age, next_en_age;
  logic [3:0] next_analog_sel;
  logic next_rc_osc_en;

  // Bus state
  logic aw_held, next_aw_held;
  logic w_held, next_w_held;
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_awready, next_wready, next_arready;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic wr_fire;

  assign wr_fire = aw_held & w_held & ~s_axi_bvalid;

  // Bus slave: address and data taken in either order, then one response
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) next_bvalid = 1'b0;
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      if (reg_hit(aw_addr, CTRL_OFF) || reg_hit(aw_addr, RESULT_OFF) ||
          reg_hit(aw_addr, DAC2_OFF)) begin
        next_bresp = RESP_OKAY;
      end else begin
        next_bresp = RESP_DECERR;
      end
    end
    if (s_axi_rvalid && s_axi_rready) next_rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = 32'h0;
      if (reg_hit(s_axi_araddr, CTRL_OFF)) begin
        next_rdata[7:0] = {enable, dac2_en, second_dac_reg_en, flag, busy, rc_sel,
                           chan};
      end else if (reg_hit(s_axi_araddr, RESULT_OFF)) begin
        next_rdata[7:0] = first_dac_result_reg;
        next_rdata[BIT_SETTLED] = (en_age == 8'(SETTLE_CYC));
      end else if (reg_hit(s_axi_araddr, DAC2_OFF)) begin
        next_rdata[7:0] = dac2;
      end else begin
        next_rresp = RESP_DECERR;
      end
    end
    // Ready only while nothing is parked, so a stalled response blocks more
    next_awready = ~next_aw_held & ~next_bvalid;
    next_wready = ~next_w_held & ~next_bvalid;
    next_arready = ~next_rvalid;
  end

  always_ff @(posedge clock or negedge rst_s_n) begin
    if (!rst_s_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_arready <= next_arready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end

  // Control writes and SAR sequencer
  logic wr_ctrl, wr_res, wr_dac2, start_req, tick;
  logic [7:0] phase_len, mask, kept;

  assign wr_ctrl = wr_fire & w_strb[0] & reg_hit(aw_addr, CTRL_OFF);
  assign wr_res = wr_fire & w_strb[0] & reg_hit(aw_addr, RESULT_OFF);
  assign wr_dac2 = wr_fire & w_strb[0] & reg_hit(aw_addr, DAC2_OFF);
  assign tick = conv_rc ? rc_edge : 1'b1;

  always_comb begin
    next_enable = enable;
    next_dac2_en = dac2_en;
    next_second_dac_reg_en = second_dac_reg_en;
    next_flag = flag;
    next_busy = busy;
    next_rc_sel = rc_sel;
    next_chan = chan;
    next_first_dac_result_reg = first_dac_result_reg;
    next_dac2 = dac2;
    next_conv_rc = conv_rc;
    next_state = state;
    next_cnt = cnt;
    next_bitn = bitn;
    start_req = 1'b0;
    phase_len = 8'h0;
    mask = 8'h01 << bitn;
    kept = comp_s ? first_dac_result_reg : (first_dac_result_reg & ~mask);
    next_mc_div = (mc_div == 3'(MC_CLOCKS - 1)) ? 3'h0 : mc_div + 3'h1;
    // Settle age since enable, shown to software
    if (!enable) next_en_age = 8'h0;
    else if (en_age == 8'(SETTLE_CYC)) next_en_age = en_age;
    else next_en_age = en_age + 8'h1;
    if (wr_ctrl) begin
      if (w_data[BIT_ENABLE] || (!busy && !flag)) begin
        next_enable = w_data[BIT_ENABLE];
      end
      next_dac2_en = w_data[BIT_DAC2_EN];
      if (!busy && !flag) begin
        next_second_dac_reg_en = w_data[BIT_SECOND_DAC_REG_EN];
        next_chan = w_data[BIT_CHAN_HI:BIT_CHAN_LO];
      end
      if (!busy) next_rc_sel = w_data[BIT_RC_SEL];
      if (!w_data[BIT_FLAG]) next_flag = 1'b0;
      // Old flag checked, so a write that clears it cannot also start
      start_req = w_data[BIT_START] & enable & ~busy & ~flag;
    end
    if (wr_res && !busy && !flag) next_first_dac_result_reg = w_data[7:0];
    if (wr_dac2) next_dac2 = w_data[7:0];
    if (start_req) begin
      next_busy = 1'b1;
      next_conv_rc = next_rc_sel;
      next_state = next_rc_sel ? ST_SYNC : ST_SETTLE;
      next_cnt = 8'h0;
    end
    // Sequencer; completion placed after the write decode so its set beats a flag clear
    case (state)
      ST_IDLE: begin
      end
      ST_SYNC: begin
        if (cnt == 8'(RC_SYNC_CYC - 1)) begin
          next_state = ST_SETTLE;
          next_cnt = 8'h0;
        end else begin
          next_cnt = cnt + 8'h1;
        end
      end
      ST_SETTLE: begin
        phase_len = conv_rc ? 8'(RC_SETTLE) : 8'(CPU_SETTLE);
        if (tick) begin
          if (cnt == phase_len - 8'h1) begin
            next_state = ST_TRIAL;
            next_cnt = 8'h0;
            next_bitn = 3'h7;
            next_first_dac_result_reg = 8'h80;
          end else begin
            next_cnt = cnt + 8'h1;
          end
        end
      end
      ST_TRIAL: begin
        phase_len = conv_rc ? 8'(RC_TRIAL) : 8'(CPU_TRIAL);
        if (tick) begin
          if (cnt == phase_len - 8'h1) begin
            next_cnt = 8'h0;
            if (bitn == 3'h0) begin
              next_first_dac_result_reg = kept;
              if (conv_rc) begin
                next_state = ST_ALIGN;
              end else begin
                next_state = ST_IDLE;
                next_busy = 1'b0;
                next_flag = 1'b1;
              end
            end else begin
              next_first_dac_result_reg = kept | (mask >> 1);
              next_bitn = bitn - 3'h1;
            end
          end else begin
            next_cnt = cnt + 8'h1;
          end
        end
      end
      ST_ALIGN: begin
        // Finish on a machine-cycle boundary, the fourth sync cycle
        if (mc_div == 3'(MC_CLOCKS - 1)) begin
          next_state = ST_IDLE;
          next_busy = 1'b0;
          next_flag = 1'b1;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_busy = 1'b0;
      end
    endcase
    // Power-down stops a CPU-clocked conversion; RC-clocked ones go on
    if (busy && !conv_rc && pd_s) begin
      next_state = ST_IDLE;
      next_busy = 1'b0;
      next_flag = flag & next_flag;
    end
    next_analog_sel = chan_onehot(next_chan);
    next_rc_osc_en = next_enable & (next_rc_sel | next_busy & next_conv_rc);
  end

  always_ff @(posedge clock or negedge rst_s_n) begin
    if (!rst_s_n) begin
      enable <= CTRL_RESET[BIT_ENABLE];
      dac2_en <= CTRL_RESET[BIT_DAC2_EN];
      second_dac_reg_en <= CTRL_RESET[BIT_SECOND_DAC_REG_EN];
      flag <= CTRL_RESET[BIT_FLAG];
      busy <= CTRL_RESET[BIT_START];
      rc_sel <= CTRL_RESET[BIT_RC_SEL];
      chan <= CTRL_RESET[BIT_CHAN_HI:BIT_CHAN_LO];
      first_dac_result_reg <= DAC_RESET;
      dac2 <= DAC_RESET;
      conv_rc <= 1'b0;
      state <= ST_IDLE;
      cnt <= 8'h0;
      bitn <= 3'h0;
      mc_div <= 3'h0;
      en_age <= 8'h0;
      analog_sel <= 4'h1;
      rc_osc_enable <= 1'b0;
    end else begin
      enable <= next_enable;
      dac2_en <= next_dac2_en;
      second_dac_reg_en <= next_second_dac_reg_en;
      flag <= next_flag;
      busy <= next_busy;
      rc_sel <= next_rc_sel;
      chan <= next_chan;
      first_dac_result_reg <= next_first_dac_result_reg;
      dac2 <= next_dac2;
      conv_rc <= next_conv_rc;
      state <= next_state;
      cnt <= next_cnt;
      bitn <= next_bitn;
      mc_div <= next_mc_div;
      en_age <= next_en_age;
      analog_sel <= next_analog_sel;
      rc_osc_enable <= next_rc_osc_en;
    end
  end

  // Outputs taken straight from the register bits
  assign converter_enable = enable;
  assign first_dac_enable = second_dac_reg_en;
  assign second_dac_enable = dac2_en;
  assign first_dac_code = first_dac_result_reg;
  assign second_dac_code = dac2;
  assign conv_irq = flag;

  // Helper counters; wide enough that an RC conversion never wraps
  logic [9:0] age;
  logic [7:0] rc_age;
  always_ff @(posedge clock or negedge rst_s_n) begin
    if (!rst_s_n) begin
      age <= 10'h0;
      rc_age <= 8'h0;
    end else if (start_req) begin
      age <= 10'h0;
      rc_age <= 8'h0;
    end else if (busy) begin
      age <= age + 10'h1;
      if (rc_edge && (state == ST_SETTLE || state == ST_TRIAL)) begin
        rc_age <= rc_age + 8'h1;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_s_n);

  a_start_enabled: assert property ($rose(busy) |-> $past(enable))
    else $error("conversion started while disabled");
  a_enable_lock: assert property (
    ($past(enable) && $past(busy || flag)) |-> enable)
    else $error("enable cleared while busy or complete");
  a_dac2_follow: assert property (
    wr_ctrl |=> second_dac_enable == $past(w_data[BIT_DAC2_EN]))
    else $error("second DAC enable did not follow write");
  a_second_dac_reg_lock: assert property (
    $past(busy || flag) |-> $stable(first_dac_enable))
    else $error("first DAC enable changed while locked");
  a_cpu_time: assert property (
    ($rose(flag) && !conv_rc) |-> age == 10'(CPU_CONV_CYC))
    else $error("CPU-clocked conversion length wrong");
  a_rc_time: assert property (
    ($rose(flag) && conv_rc) |-> (rc_age == 8'(RC_CONV_TICKS) &&
      age > 10'(RC_SYNC_CYC + RC_CONV_TICKS)))
    else $error("RC-clocked conversion length wrong");
  a_rc_keeps_on: assert property (
    (busy && conv_rc && pd_s) |=> (busy || flag))
    else $error("RC conversion stopped in power-down");
  a_rc_osc_run: assert property (
    (busy && conv_rc && $past(busy)) |-> rc_osc_enable)
    else $error("RC oscillator off during RC conversion");
  a_busy_to_flag: assert property (
    ($fell(busy) && !$past(pd_s)) |-> $rose(flag))
    else $error("busy cleared without completion");
  a_no_restart: assert property ($rose(busy) |-> !$past(flag))
    else $error("conversion started with flag set");
  a_result_hold: assert property (
    (!busy && !$past(busy) && !$past(wr_res)) |-> $stable(first_dac_code))
    else $error("result changed while idle");
  a_chan_lock: assert property ($past(busy) |-> $stable(chan))
    else $error("channel changed during conversion");
  a_chan_route: assert property (
    $past(busy) |-> analog_sel == chan_onehot(chan))
    else $error("analog select does not match channel");
  a_flag_sticky: assert property (
    $fell(flag) |-> ($past(wr_ctrl) && !$past(w_data[BIT_FLAG])))
    else $error("complete flag cleared without a write");

endmodule // adcc_conv_ctrl

// [test/adcc_conv_ctrl_bench.sv]
// Purpose: Self-checking bench for the converter control block.
// Assumes: AXI4-Lite register access; comparator held at a fixed level through each conversion.
// Notes: RC oscillator runs free with a 6-clock period on the bench side.
`timescale 1ns/1ps
module adcc_conv_ctrl_bench;
  import adcc_pkg::*;
  localparam int RC_P = 6;
  localparam int RC_LO = RC_SYNC_CYC + (RC_CONV_TICKS - 1) * RC_P;
  localparam int RC_HI = 4 * MC_CLOCKS + 112 * RC_P;
  localparam int LIMIT = 20000;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic power_down = 1'b0;
  logic rc_osc_clk = 1'b0;
  logic comp_high = 1'b0;
  logic converter_enable, rc_osc_enable, first_dac_enable, second_dac_enable;
  logic [3:0] analog_sel;
  logic [7:0] first_dac_code, second_dac_code;
  logic conv_irq;
  logic [31:0] rdat;
  logic [1:0] rrsp, brsp;
  logic bv_q = 1'b0;
  logic irq_q = 1'b0;
  int cyc = 0;
  int wr_cyc = 0;
  int irq_cyc = 0;
  int rc_cnt = 0;
  int n_errors = 0;
  int n_checks = 0;
  int t0;
  logic [7:0] e;

  adcc_conv_ctrl DUT (
    .clock(clock), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .power_down(power_down),
    .rc_osc_clk(rc_osc_clk), .comp_high(comp_high),
    .converter_enable(converter_enable), .rc_osc_enable(rc_osc_enable),
    .first_dac_enable(first_dac_enable),
    .second_dac_enable(second_dac_enable), .analog_sel(analog_sel),
    .first_dac_code(first_dac_code), .second_dac_code(second_dac_code),
    .conv_irq(conv_irq)
  );

  // 100 ns clock
  always #50 clock = ~clock;

  // Free-running RC oscillator, slower than the system clock
  always @(posedge clock) begin
    rc_cnt <= (rc_cnt == RC_P / 2 - 1) ? 0 : rc_cnt + 1;
    if (rc_cnt == RC_P / 2 - 1) rc_osc_clk <= ~rc_osc_clk;
  end

  // Edge stamps for timing checks; both stamps lag by one edge alike
  always @(posedge clock) begin
    cyc <= cyc + 1;
    bv_q <= s_axi_bvalid;
    irq_q <= conv_irq;
    if (s_axi_bvalid === 1'b1 && bv_q === 1'b0) wr_cyc <= cyc;
    if (conv_irq === 1'b1 && irq_q === 1'b0) irq_cyc <= cyc;
    if (cyc == LIMIT) give_up("run");
  end

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Any wait that runs out is a mismatch and ends the run
  task automatic give_up(input string what);
    n_errors++;
    $display("MISMATCH at %0t: %s timed out", $time, what);
    summarize();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_span(input int v, input int lo, input int hi,
                          input string what);
    n_checks++;
    if (v < lo || v > hi) begin
      n_errors++;
      $display("MISMATCH at %0t: %s took %0d not in %0d..%0d", $time, what,
               v, lo, hi);
    end
  endtask

  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bit aw_p, w_p, b_p;
    int n;
    aw_p = 1;
    w_p = 1;
    b_p = 1;
    n = 0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (b_p && n < 100) begin
      @(posedge clock);
      n++;
      if (aw_p && s_axi_awready === 1'b1) begin
        aw_p = 0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_p && s_axi_wready === 1'b1) begin
        w_p = 0;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid === 1'b1) begin
        b_p = 0;
        brsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
    if (b_p) give_up("write");
  endtask

  // Read: rready held until the data beat is seen
  task automatic rd(input logic [7:0] a);
    bit ar_p, r_p;
    int n;
    ar_p = 1;
    r_p = 1;
    n = 0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (r_p && n < 100) begin
      @(posedge clock);
      n++;
      if (ar_p && s_axi_arready === 1'b1) begin
        ar_p = 0;
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid === 1'b1) begin
        r_p = 0;
        rdat = s_axi_rdata;
        rrsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
    if (r_p) give_up("read");
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rdat, exp, "register read");
  endtask

  // Bounded wait for completion, then let the stamps settle
  task automatic wait_irq();
    int n;
    n = 0;
    while (conv_irq !== 1'b1 && n < 2000) begin
      @(posedge clock);
      n++;
    end
    if (conv_irq !== 1'b1) give_up("completion");
    repeat (2) @(posedge clock);
  endtask

  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    rd_chk(CTRL_OFF, 32'h0);
    rd_chk(RESULT_OFF, 32'h0);
    rd_chk(DAC2_OFF, 32'h0);
    chk(32'(analog_sel), 32'h1, "reset channel");
    rd(8'hd0);
    chk(32'(rrsp), 32'(RESP_DECERR), "unmapped read");
    wr(8'hd0, 8'hff);
    chk(32'(brsp), 32'(RESP_DECERR), "unmapped write");
    wr(DAC2_OFF, 8'h5a);
    chk(32'(brsp), 32'(RESP_OKAY), "write response");
    rd_chk(DAC2_OFF, 32'h5a);
    chk(32'(second_dac_code), 32'h5a, "second dac code");
    wr(RESULT_OFF, 8'h3c);
    rd_chk(RESULT_OFF, 32'h3c);
    $display("Test registers finished");
    wr(CTRL_OFF, 8'h08);
    repeat (CPU_CONV_CYC + 10) @(posedge clock);
    rd_chk(CTRL_OFF, 32'h0);
    chk(32'(conv_irq), 32'h0, "start while disabled");
    wr(CTRL_OFF, 8'h60);
    chk(32'(first_dac_enable), 32'h1, "first dac enable");
    chk(32'(second_dac_enable), 32'h1, "second dac enable");
    wr(CTRL_OFF, 8'h00);
    chk(32'(second_dac_enable), 32'h0, "second dac off");
    $display("Test enables finished");
    // Enable first and let the analog side settle before any start
    wr(CTRL_OFF, 8'h80);
    chk(32'(converter_enable), 32'h1, "converter enable");
    repeat (SETTLE_CYC + 10) @(posedge clock);
    rd_chk(RESULT_OFF, 32'h13c);
    for (int ch = 0; ch < 4; ch++) begin
      e = ch[0] ? 8'h00 : 8'hff;
      comp_high <= ~ch[0];
      wr(CTRL_OFF, 8'h88 | 8'(ch));
      @(posedge clock);
      t0 = wr_cyc;
      chk(32'(analog_sel), 32'(4'h1 << ch), "channel one-hot");
      rd_chk(CTRL_OFF, 32'h88 | ch);
      wr(CTRL_OFF, 8'h20 | 8'(ch ^ 3));
      wr(RESULT_OFF, 8'h11);
      rd_chk(CTRL_OFF, 32'h88 | ch);
      chk(32'(first_dac_enable), 32'h0, "locked dac enable");
      wait_irq();
      chk_span(irq_cyc - t0, CPU_CONV_CYC, CPU_CONV_CYC, "cpu conv");
      rd_chk(CTRL_OFF, 32'h90 | ch);
      wr(CTRL_OFF, 8'h98 | 8'(ch));
      wr(RESULT_OFF, 8'h22);
      rd_chk(CTRL_OFF, 32'h90 | ch);
      chk(32'(conv_irq), 32'h1, "flag holds");
      rd_chk(RESULT_OFF, 32'h100 | e);
      chk(32'(first_dac_code), 32'(e), "result code");
      wr(CTRL_OFF, 8'h80 | 8'(ch));
      rd_chk(CTRL_OFF, 32'h80 | ch);
      chk(32'(conv_irq), 32'h0, "flag cleared");
    end
    $display("Test cpu conversions finished");
    comp_high <= 1'b1;
    wr(CTRL_OFF, 8'h86);
    chk(32'(rc_osc_enable), 32'h1, "rc oscillator on");
    wr(CTRL_OFF, 8'h8e);
    @(posedge clock);
    t0 = wr_cyc;
    repeat (2 * MC_CLOCKS) @(posedge clock);
    power_down <= 1'b1;
    wait_irq();
    power_down <= 1'b0;
    chk_span(irq_cyc - t0, RC_LO, RC_HI, "rc conv");
    rd_chk(CTRL_OFF, 32'h96);
    rd_chk(RESULT_OFF, 32'h1ff);
    wr(CTRL_OFF, 8'h86);
    wr(CTRL_OFF, 8'h80);
    rd_chk(CTRL_OFF, 32'h80);
    chk(32'(rc_osc_enable), 32'h0, "rc oscillator off");
    $display("Test rc conversion finished");
    wr(CTRL_OFF, 8'h88);
    repeat (2 * MC_CLOCKS) @(posedge clock);
    power_down <= 1'b1;
    repeat (10) @(posedge clock);
    power_down <= 1'b0;
    repeat (CPU_CONV_CYC) @(posedge clock);
    rd_chk(CTRL_OFF, 32'h80);
    chk(32'(conv_irq), 32'h0, "aborted conversion");
    $display("Test power-down abort finished");
    summarize();
  end
endmodule  // adcc_conv_ctrl_bench
